// ===== rtl/micp_capture.sv
// Command, address and write data capture front end
`timescale 1ns/1ps
`default_nettype none
`include "micp_cfg.svh"

module micp_capture #(
	parameter int DATA_W      = `MICP_DATA_W,
	parameter int BURST_WORDS = `MICP_BURST_WORDS,
	parameter int FIFO_DEPTH  = `MICP_FIFO_DEPTH
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    clock_p,
	input  wire logic                    clock_n,
	input  wire logic                    chip_select_n,
	input  wire logic                    write_enable_n,
	input  wire logic                    refresh_n,
	input  wire logic [`MICP_ADDR_W-1:0] addr_lines,
	input  wire logic [`MICP_BANK_W-1:0] bank_select,
	input  wire logic                    write_data_clock_lo,
	input  wire logic                    write_data_clock_lo_n,
	input  wire logic                    write_data_clock_hi,
	input  wire logic                    write_data_clock_hi_n,
	input  wire logic                    write_mask,
	input  wire logic [DATA_W-1:0]       data_in,
	output logic                         read_data_clock,
	output logic                         read_data_clock_n,
	output logic                         read_valid_flag,
	output logic                         cmd_valid,
	output micp_pkg::micp_cmd_t          cmd_kind,
	output logic [`MICP_ADDR_W-1:0]      cmd_addr,
	output logic [`MICP_BANK_W-1:0]      cmd_bank,
	output logic [`MICP_ADDR_W-1:0]      config_word,
	output logic                         burst_active,
	output logic                         overrun,
	output logic                         word_valid,
	input  wire logic                    word_ready,
	output logic [DATA_W-1:0]            word_data
);
	localparam int LANES = (DATA_W == 36) ? 2 : 1;
	localparam int LW    = DATA_W / LANES;
	localparam int SW    = 10 + `MICP_BANK_W + `MICP_ADDR_W + DATA_W;
	localparam int QW    = $clog2(`MICP_QK_HALF_CYC) + 1;
	localparam int BW    = $clog2(BURST_WORDS) + 1;

	function automatic micp_pkg::micp_cmd_t decode_cmd(
		input logic we_n,
		input logic ref_n
	);
		case ({we_n, ref_n})
			2'b11:   decode_cmd = micp_pkg::MICP_CMD_READ;
			2'b01:   decode_cmd = micp_pkg::MICP_CMD_WRITE;
			2'b10:   decode_cmd = micp_pkg::MICP_CMD_AREF;
			default: decode_cmd = micp_pkg::MICP_CMD_CFG;
		endcase
	endfunction

	// Pin synchroniser
	logic [SW-1:0] s1_q;
	logic [SW-1:0] s2_q;
	logic ck_p_s, ck_n_s, cs_n_s, we_n_s, ref_n_s, mask_s;
	logic dk_hi_s, dk_hi_n_s, dk_lo_s, dk_lo_n_s;
	logic [`MICP_BANK_W-1:0] bank_s;
	logic [`MICP_ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0]       data_s;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {clock_p, clock_n, chip_select_n, write_enable_n,
				refresh_n, write_data_clock_hi, write_data_clock_hi_n,
				write_data_clock_lo, write_data_clock_lo_n, write_mask,
				bank_select, addr_lines, data_in};
			s2_q <= s1_q;
		end
	end

	assign {ck_p_s, ck_n_s, cs_n_s, we_n_s, ref_n_s, dk_hi_s, dk_hi_n_s,
		dk_lo_s, dk_lo_n_s, mask_s, bank_s, addr_s, data_s} = s2_q;

	// Edge detection on differential levels
	logic             ck_lvl;
	logic             ck_prev_q;
	logic             ck_rise;
	logic [LANES-1:0] dk_lvl;
	logic [LANES-1:0] dk_prev_q;
	logic [LANES-1:0] dk_edge;

	assign ck_lvl  = ck_p_s & ~ck_n_s;
	assign ck_rise = ck_lvl & ~ck_prev_q;

	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++) begin : g_lane
			if (gl == 0) begin : g_lo
				assign dk_lvl[gl] = dk_lo_s & ~dk_lo_n_s;
			end else begin : g_hi
				assign dk_lvl[gl] = dk_hi_s & ~dk_hi_n_s;
			end
			assign dk_edge[gl] = dk_lvl[gl] ^ dk_prev_q[gl];
		end
	endgenerate

	// Command, capture and read-flag state
	logic                    cmd_valid_q, cmd_valid_d;
	micp_pkg::micp_cmd_t     cmd_kind_q, cmd_kind_d;
	logic [`MICP_ADDR_W-1:0] cmd_addr_q, cmd_addr_d;
	logic [`MICP_BANK_W-1:0] cmd_bank_q, cmd_bank_d;
	logic [`MICP_ADDR_W-1:0] cfg_q, cfg_d;
	micp_pkg::micp_win_t     win_q, win_d;
	logic [BW-1:0]           left_q, left_d;
	logic [DATA_W-1:0]       half_q, half_d;
	logic [LANES-1:0]        got_q, got_d;
	logic                    mask_q, mask_d;
	logic                    pend_q, pend_d;
	logic [DATA_W-1:0]       pend_data_q, pend_data_d;
	logic                    ovr_q, ovr_d;
	logic                    rd_pend_q, rd_pend_d;
	logic                    rvalid_q, rvalid_d;
	logic [QW-1:0]           qk_cnt_q, qk_cnt_d;
	logic                    qk_q, qk_d;
	logic                    fifo_ready;
	micp_pkg::micp_cmd_t     cmd_now;

	always_comb begin
		cmd_valid_d = 1'b0;
		cmd_kind_d  = cmd_kind_q;
		cmd_addr_d  = cmd_addr_q;
		cmd_bank_d  = cmd_bank_q;
		cfg_d       = cfg_q;
		win_d       = win_q;
		left_d      = left_q;
		half_d      = half_q;
		got_d       = got_q;
		mask_d      = mask_q;
		pend_d      = pend_q && !fifo_ready;
		pend_data_d = pend_data_q;
		ovr_d       = ovr_q;
		rd_pend_d   = rd_pend_q;
		rvalid_d    = rvalid_q;
		qk_cnt_d    = qk_cnt_q + 1'b1;
		qk_d        = qk_q;
		cmd_now     = decode_cmd(we_n_s, ref_n_s);

		// Lane capture, held off while a word waits for the FIFO
		for (int l = 0; l < LANES; l++) begin
			if (dk_edge[l]) begin
				if (pend_q) begin
					ovr_d = 1'b1;
				end else begin
					half_d[l*LW +: LW] = data_s[l*LW +: LW];
					got_d[l] = 1'b1;
					if (l == LANES - 1) begin
						mask_d = mask_s;
					end
				end
			end
		end

		// Word assembled; counts against the open burst
		if (&got_d) begin
			got_d = '0;
			if (win_q == micp_pkg::MICP_WIN_BURST) begin
				left_d = left_q - 1'b1;
				if (left_q == BW'(1)) begin
					win_d = micp_pkg::MICP_WIN_IDLE;
				end
				if (!mask_d) begin
					pend_d      = 1'b1;
					pend_data_d = half_d;
				end
			end
		end

		// Command decode, only while selected
		if (ck_rise && !cs_n_s) begin
			cmd_valid_d = 1'b1;
			cmd_kind_d  = cmd_now;
			cmd_addr_d  = addr_s;
			cmd_bank_d  = bank_s;
			case (cmd_now)
				micp_pkg::MICP_CMD_CFG: begin
					cfg_d = addr_s;
				end
				micp_pkg::MICP_CMD_WRITE: begin
					win_d  = micp_pkg::MICP_WIN_BURST;
					left_d = BW'(BURST_WORDS);
				end
				micp_pkg::MICP_CMD_READ: begin
					rd_pend_d = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// Free-running read clock; flag moves on its rise
		if (qk_cnt_q == QW'(`MICP_QK_HALF_CYC - 1)) begin
			qk_cnt_d = '0;
			qk_d     = !qk_q;
			if (!qk_q) begin
				rvalid_d = rd_pend_q;
				if (!(ck_rise && !cs_n_s &&
					cmd_now == micp_pkg::MICP_CMD_READ)) begin
					rd_pend_d = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ck_prev_q   <= 1'b0;
			dk_prev_q   <= '0;
			cmd_valid_q <= 1'b0;
			cmd_kind_q  <= micp_pkg::MICP_CMD_NOP;
			cmd_addr_q  <= '0;
			cmd_bank_q  <= '0;
			cfg_q       <= `MICP_CFG_RST;
			win_q       <= micp_pkg::MICP_WIN_IDLE;
			left_q      <= '0;
			half_q      <= '0;
			got_q       <= '0;
			mask_q      <= 1'b0;
			pend_q      <= 1'b0;
			pend_data_q <= '0;
			ovr_q       <= 1'b0;
			rd_pend_q   <= 1'b0;
			rvalid_q    <= 1'b0;
			qk_cnt_q    <= '0;
			qk_q        <= 1'b0;
		end else begin
			ck_prev_q   <= ck_lvl;
			dk_prev_q   <= dk_lvl;
			cmd_valid_q <= cmd_valid_d;
			cmd_kind_q  <= cmd_kind_d;
			cmd_addr_q  <= cmd_addr_d;
			cmd_bank_q  <= cmd_bank_d;
			cfg_q       <= cfg_d;
			win_q       <= win_d;
			left_q      <= left_d;
			half_q      <= half_d;
			got_q       <= got_d;
			mask_q      <= mask_d;
			pend_q      <= pend_d;
			pend_data_q <= pend_data_d;
			ovr_q       <= ovr_d;
			rd_pend_q   <= rd_pend_d;
			rvalid_q    <= rvalid_d;
			qk_cnt_q    <= qk_cnt_d;
			qk_q        <= qk_d;
		end
	end

	micp_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (pend_q),
		.in_ready  (fifo_ready),
		.in_data   (pend_data_q),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

	assign read_data_clock   = qk_q;
	assign read_data_clock_n = !qk_q;
	assign read_valid_flag   = rvalid_q;
	assign cmd_valid         = cmd_valid_q;
	assign cmd_kind          = cmd_kind_q;
	assign cmd_addr          = cmd_addr_q;
	assign cmd_bank          = cmd_bank_q;
	assign config_word       = cfg_q;
	assign burst_active      = (win_q == micp_pkg::MICP_WIN_BURST);
	assign overrun           = ovr_q;
endmodule
`default_nettype wire

// ===== rtl/micp_fifo.sv
// Write data FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module micp_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    wr_d;
	logic [AW-1:0]    rd_q;
	logic [AW-1:0]    rd_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             out_valid_q;
	logic             out_valid_d;
	logic [WIDTH-1:0] out_data_q;
	logic [WIDTH-1:0] out_data_d;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready    = (cnt_q != (AW+1)'(DEPTH));
		push        = in_valid && in_ready;
		pop         = (cnt_q != '0) && (!out_valid_q || out_ready);
		wr_d        = push ? wr_q + 1'b1 : wr_q;
		rd_d        = pop ? rd_q + 1'b1 : rd_q;
		cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		out_valid_d = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
		out_data_d  = pop ? mem_q[rd_q] : out_data_q;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_q        <= '0;
			rd_q        <= '0;
			cnt_q       <= '0;
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else begin
			wr_q        <= wr_d;
			rd_q        <= rd_d;
			cnt_q       <= cnt_d;
			out_valid_q <= out_valid_d;
			out_data_q  <= out_data_d;
		end
	end

	// Storage array, no reset needed
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	assign out_valid = out_valid_q;
	assign out_data  = out_data_q;
endmodule
`default_nettype wire

// ===== shared/micp_cfg.svh
// Constants for the memory input capture port
`ifndef MICP_CFG_SVH
`define MICP_CFG_SVH

`define MICP_ADDR_W        21
`define MICP_BANK_W        3
`define MICP_DATA_W        36
`define MICP_BURST_WORDS   2
`define MICP_FIFO_DEPTH    8
`define MICP_CFG_RST       21'h0_0000
`define MICP_SYS_PERIOD_NS 100
`define MICP_QK_PERIOD_NS  800
`define MICP_QK_HALF_CYC   ((`MICP_QK_PERIOD_NS / `MICP_SYS_PERIOD_NS) / 2)

`endif

// ===== shared/micp_pkg.sv
// Types for the memory input capture port
`default_nettype none
package micp_pkg;
	typedef enum logic [4:0] {
		MICP_CMD_NOP   = 5'h01,
		MICP_CMD_READ  = 5'h02,
		MICP_CMD_WRITE = 5'h04,
		MICP_CMD_AREF  = 5'h08,
		MICP_CMD_CFG   = 5'h10
	} micp_cmd_t;
	typedef enum logic [1:0] {
		MICP_WIN_IDLE  = 2'h1,
		MICP_WIN_BURST = 2'h2
	} micp_win_t;
endpackage
`default_nettype wire

// ===== test/micp_capture_bench.sv
// Self-checking bench for the memory input capture port
`timescale 1ns/1ps
`default_nettype none
module micp_capture_bench;
	typedef struct {
		logic w, r;
		logic [2:0] b;
		logic [20:0] a;
		logic [4:0] k;
	} micp_row_t;
	logic		clk_sys, rst, clock_p, clock_n, chip_select_n;
	logic		write_enable_n, refresh_n, write_mask, word_ready;
	logic		write_data_clock_lo, write_data_clock_lo_n;
	logic		write_data_clock_hi, write_data_clock_hi_n;
	logic		read_data_clock, read_data_clock_n, read_valid_flag;
	logic		cmd_valid, burst_active, overrun, word_valid;
	logic [20:0]	addr_lines, cmd_addr, config_word;
	logic [2:0]	bank_select, cmd_bank;
	logic [35:0]	data_in, word_data;
	logic [35:0]	got [$];
	micp_pkg::micp_cmd_t	cmd_kind;
	int		error_cnt, checks_done, n_cmd, n0, base, n_rv;
	micp_row_t	rows [4] = '{'{1, 1, 3'h1, 21'h1F_FFFF, 5'h02},
		'{1, 0, 3'h0, 21'h0_0000, 5'h08}, '{0, 0, 3'h5, 21'h0_A5A5, 5'h10},
		'{0, 1, 3'h7, 21'h1_2345, 5'h04}};
	micp_capture u_dut (
		.clk_sys, .rst, .clock_p, .clock_n, .chip_select_n,
		.write_enable_n, .refresh_n, .addr_lines, .bank_select,
		.write_data_clock_lo, .write_data_clock_lo_n,
		.write_data_clock_hi, .write_data_clock_hi_n, .write_mask,
		.data_in, .read_data_clock, .read_data_clock_n,
		.read_valid_flag, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_bank,
		.config_word, .burst_active, .overrun, .word_valid, .word_ready,
		.word_data
	);
	micp_ctl_model u_ctl (
		.clock_p, .clock_n, .chip_select_n, .write_enable_n, .refresh_n,
		.addr_lines, .bank_select, .write_data_clock_lo,
		.write_data_clock_lo_n, .write_data_clock_hi,
		.write_data_clock_hi_n, .write_mask, .data_in
	);
	function automatic logic [35:0] pat(input int i);
		return {18'h2_A000 + 18'(i), 18'h0_5000 + 18'(i)};
	endfunction
	task automatic chk(input string what, input logic [35:0] exp,
			input logic [35:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 300 && got.size() < n; i++)
			@(posedge clk_sys);
		repeat (30) @(posedge clk_sys);
		#1;
	endtask
	// Write commands, then a deselected refresh, beside a word stream
	task automatic wr(input int i0, nw, nc, input logic [15:0] m);
		@(posedge clock_p);
		#1;
		fork
			begin
				repeat (nc) u_ctl.cmd(0, 0, 1, 21'h0_0042, 3'h2);
				u_ctl.cmd(1, 1, 0, 21'h0_0000, 3'h0);
			end
			begin
				// First word must stand before the first data edge
				@(negedge clock_p);
				base = got.size();
				n0 = n_cmd;
				for (int i = 0; i < nw; i++) begin
					u_ctl.put(pat(i0 + i), m[i]);
					if (i == 1)
						chk("burst_active", 1'b1, burst_active);
				end
			end
		join
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1)
			n_cmd++;
		if (read_valid_flag === 1'b1)
			n_rv++;
		if (word_valid === 1'b1 && word_ready === 1'b1)
			got.push_back(word_data);
	end
	initial begin
		#200_000;
		error_cnt++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		word_ready = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		foreach (rows[i]) begin
			n0 = n_cmd;
			u_ctl.cmd(0, rows[i].w, rows[i].r, rows[i].a, rows[i].b);
			repeat (6) @(posedge clk_sys);
			#1;
			chk("pulses", n0 + 1, n_cmd);
			chk("cmd_kind", rows[i].k, cmd_kind);
			chk("cmd_addr", rows[i].a, cmd_addr);
			chk("cmd_bank", rows[i].b, cmd_bank);
		end
		chk("config_word", 21'h0_A5A5, config_word);
		chk("read_valid", 36'h0_0000_0008, n_rv);
		$display("test commands done");
		wr(1, 3, 1, 16'h0000);
		wait_got(base + 2);
		chk("words", base + 2, got.size());
		chk("word a", pat(1), got[base]);
		chk("word b", pat(2), got[base + 1]);
		chk("pulses", n0 + 1, n_cmd);
		chk("cmd_kind", 5'h04, cmd_kind);
		$display("test burst done");
		wr(4, 3, 1, 16'h0001);
		wait_got(base + 1);
		chk("words", base + 1, got.size());
		chk("word", pat(5), got[base]);
		$display("test mask done");
		word_ready = 1'b0;
		wr(20, 16, 8, 16'h0000);
		@(posedge clk_sys);
		#1;
		chk("overrun", 1'b1, overrun);
		word_ready = 1'b1;
		// Eight stored, one in the output register, one pending
		wait_got(base + 10);
		for (int k = 0; k < 10; k++)
			chk("queued", pat(20 + k), got[base + k]);
		$display("test overrun done");
		rst = 1'b1;
		@(posedge clk_sys);
		#1;
		chk("cmd_kind", 5'h01, cmd_kind);
		chk("overrun", 1'b0, overrun);
		chk("config_word", 21'h0_0000, config_word);
		chk("word_valid", 1'b0, word_valid);
		chk("burst_active", 1'b0, burst_active);
		chk("read_data_clock", 1'b0, read_data_clock);
		chk("read_data_clock_n", 1'b1, read_data_clock_n);
		rst = 1'b0;
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire

// ===== test/micp_capture_sva.sv
// Assertion checker for the memory input capture port
`timescale 1ns/1ps
`default_nettype none
module micp_capture_chk #(
	parameter int DATA_W = 36
) (
	input wire logic			clk_sys,
	input wire logic			rst,
	input wire logic			clock_p,
	input wire logic			chip_select_n,
	input wire logic			write_enable_n,
	input wire logic			refresh_n,
	input wire logic [20:0]		addr_lines,
	input wire logic [2:0]		bank_select,
	input wire logic			read_data_clock,
	input wire logic			read_valid_flag,
	input wire logic			cmd_valid,
	input wire micp_pkg::micp_cmd_t	cmd_kind,
	input wire logic [20:0]		cmd_addr,
	input wire logic [2:0]		cmd_bank,
	input wire logic [20:0]		config_word,
	input wire logic			word_valid,
	input wire logic			word_ready,
	input wire logic [DATA_W-1:0]	word_data
);
	localparam logic [4:0] KIND [4] = '{5'h10, 5'h04, 5'h08, 5'h02};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence rclk_high; read_data_clock [*4]; endsequence
	sequence rclk_low; !read_data_clock [*4]; endsequence
	chk_clk_rise: assert property (
		cmd_valid |-> $past(clock_p, 3) && !$past(clock_p, 7))
		else $error("command without main clock rise");
	chk_select_gate: assert property (
		cmd_valid |-> !$past(chip_select_n, 3))
		else $error("command while deselected");
	chk_kind_code: assert property (
		cmd_valid |-> cmd_kind ==
		KIND[{$past(write_enable_n, 3), $past(refresh_n, 3)}])
		else $error("command kind wrong");
	chk_addr_bank: assert property (
		cmd_valid |-> cmd_addr == $past(addr_lines, 3) &&
		cmd_bank == $past(bank_select, 3))
		else $error("address or bank wrong");
	chk_cfg_copy: assert property (
		cmd_valid && cmd_kind == 5'h10 |-> ##[0:1] config_word == cmd_addr)
		else $error("config word not stored");
	chk_word_hold: assert property (
		word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("word dropped before taken");
	chk_rclk_shape: assert property (
		$rose(read_data_clock) |-> rclk_high ##1 rclk_low ##1 read_data_clock)
		else $error("read clock shape wrong");
	chk_rvalid_edge: assert property (
		$changed(read_valid_flag) |-> $rose(read_data_clock))
		else $error("read valid off clock edge");
endmodule
bind micp_capture micp_capture_chk #(.DATA_W(DATA_W)) u_chk (
	.clk_sys, .rst, .clock_p, .chip_select_n, .write_enable_n, .refresh_n,
	.addr_lines, .bank_select, .read_data_clock, .read_valid_flag,
	.cmd_valid, .cmd_kind, .cmd_addr, .cmd_bank, .config_word,
	.word_valid, .word_ready, .word_data
);
`default_nettype wire

// ===== test/micp_ctl_model.sv
// Controller model driving the capture port pins
`timescale 1ns/1ps
`default_nettype none
module micp_ctl_model #(
	parameter int DATA_W = 36
) (
	output logic			clock_p,
	output logic			clock_n,
	output logic			chip_select_n,
	output logic			write_enable_n,
	output logic			refresh_n,
	output logic [20:0]		addr_lines,
	output logic [2:0]		bank_select,
	output logic			write_data_clock_lo,
	output logic			write_data_clock_lo_n,
	output logic			write_data_clock_hi,
	output logic			write_data_clock_hi_n,
	output logic			write_mask,
	output logic [DATA_W-1:0]	data_in
);
	assign clock_n = ~clock_p;
	assign write_data_clock_lo_n = ~write_data_clock_lo;
	assign #30 write_data_clock_hi = write_data_clock_lo;
	assign write_data_clock_hi_n = ~write_data_clock_hi;
	initial begin
		{chip_select_n, write_enable_n, refresh_n} = 3'h7;
		{addr_lines, bank_select, write_mask, data_in} = '0;
		clock_p = 1'b0;
		forever #400 clock_p = ~clock_p;
	end
	initial begin
		write_data_clock_lo = 1'b0;
		#200;
		forever #400 write_data_clock_lo = ~write_data_clock_lo;
	end
	// Command held around one main clock rise
	task automatic cmd(input logic c, w, r, input logic [20:0] a,
			input logic [2:0] b);
		@(negedge clock_p);
		#1;
		{chip_select_n, write_enable_n, refresh_n} = {c, w, r};
		{addr_lines, bank_select} = {a, b};
		@(posedge clock_p);
		#300;
		chip_select_n = 1'b1;
		addr_lines = ~a;
	endtask
	// One word per data clock edge
	task automatic put(input logic [DATA_W-1:0] d, input logic m);
		@(write_data_clock_lo);
		#200;
		data_in = d;
		write_mask = m;
	endtask
endmodule
`default_nettype wire
